// [dv/chlc_far_model.sv]
// far-side model: drum and card word sources feeding a core memory
`timescale 1ns/1ns
module chlc_far_model
    import chlc_pkg::*;
#(
    parameter int DRUM_N = 512,
    parameter int CARD_N = 20
)(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               stall_i,
    input  wire logic               drum_req_i,
    input  wire logic               card_req_i,
    input  wire logic               mem_we_i,
    input  wire logic [CHLC_AW-1:0] mem_adr_i,
    input  wire logic [CHLC_DW-1:0] mem_dat_i,
    output logic                    drum_vld_o,
    output logic      [CHLC_DW-1:0] drum_dat_o,
    output logic                    card_vld_o,
    output logic      [CHLC_DW-1:0] card_dat_o,
    output int                      wr_cnt_o
);
    // ---------------------------------------------------------------
    // sources and core
    // ---------------------------------------------------------------
    logic [CHLC_DW-1:0] core_q [1024];
    int                 drum_n_q;
    int                 card_n_q;
    logic               tick_q;

    // word sources; idle data lines invert on every idle cycle, starting from the last word
    // so a design that samples without valid sees garbage, not zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drum_vld_o <= 1'b0;
            card_vld_o <= 1'b0;
            drum_dat_o <= '0;
            card_dat_o <= '0;
            drum_n_q   <= 0;
            card_n_q   <= 0;
            tick_q     <= 1'b0;
            wr_cnt_o   <= 0;
        end else begin
            tick_q     <= ~tick_q;
            drum_vld_o <= 1'b0;
            card_vld_o <= 1'b0;
            drum_dat_o <= ~drum_dat_o;
            card_dat_o <= ~card_dat_o;
            if (!drum_req_i) begin
                drum_n_q <= 0;
            end else if (drum_n_q < DRUM_N && !(stall_i && tick_q)) begin
                drum_vld_o <= 1'b1;
                drum_dat_o <= 48'hD000_0000_0000 | CHLC_DW'(drum_n_q);
                drum_n_q   <= drum_n_q + 1;
            end
            // one binary card of 20 words
            if (!card_req_i) begin
                card_n_q <= 0;
            end else if (card_n_q < CARD_N && !(stall_i && tick_q)) begin
                card_vld_o <= 1'b1;
                card_dat_o <= 48'hC000_0000_0000 | CHLC_DW'(card_n_q);
                card_n_q   <= card_n_q + 1;
            end
            if (mem_we_i) begin
                core_q[mem_adr_i[9:0]] <= mem_dat_i;
                wr_cnt_o               <= wr_cnt_o + 1;
            end
        end
    end
endmodule : chlc_far_model

// [dv/tb_top.sv]
// self-checking bench for the console halt and load control
`timescale 1ns/1ns
module tb_top
    import chlc_pkg::*;
;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic               clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic               cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]         adr = 4'h0, wsel = 4'h0;
    logic [31:0]        wdat = 32'h0, rdat, dat_o;
    logic               ack, force_o, start_o, pdown_o, stall = 1'b0;
    logic [1:0]         idle = 2'h0, parity = 2'h0, nsf = 2'h3, halt_o;
    logic [CHLC_AW-1:0] start_adr, m_adr;
    chlc_units_s        avail = chlc_units_s'(17'h1FFFF);
    chlc_units_s        busy = chlc_units_s'(17'h00000);
    logic               m_we, d_req, d_vld, c_req, c_vld, p_main, p_drum;
    logic [CHLC_DW-1:0] m_dat, d_dat, c_dat;
    logic [1:0]         d_unit, c_unit;
    logic [7:0]         d_band;
    chlc_lamps_s        lamps;
    int                 wr_cnt, n_fail = 0, comparisons = 0;
    int                 n_idle = 0, n_start = 0, n_pdown = 0, n_creq = 0;
    logic               sel = 1'b0;

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    chlc_console chlc_console_inst (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(wsel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .proc_idle_i(idle), .proc_parity_i(parity),
        .normal_state_flag_i(nsf), .proc_halt_o(halt_o),
        .proc_idle_force_o(force_o), .proc_start_o(start_o),
        .proc_start_adr_o(start_adr), .unit_avail_i(avail),
        .unit_busy_i(busy), .mem_we_o(m_we), .mem_adr_o(m_adr),
        .mem_dat_o(m_dat), .drum_req_o(d_req), .drum_unit_o(d_unit),
        .drum_band_o(d_band), .drum_vld_i(d_vld), .drum_dat_i(d_dat),
        .card_req_o(c_req), .card_unit_o(c_unit), .card_vld_i(c_vld),
        .card_dat_i(c_dat), .power_main_o(p_main), .power_drum_o(p_drum),
        .power_down_o(pdown_o), .lamps_o(lamps));

    chlc_far_model chlc_far_model_inst (.clk_i(clk_i), .rst_i(rst_i),
        .stall_i(stall), .drum_req_i(d_req), .card_req_i(c_req),
        .mem_we_i(m_we), .mem_adr_i(m_adr), .mem_dat_i(m_dat),
        .drum_vld_o(d_vld), .drum_dat_o(d_dat), .card_vld_o(c_vld),
        .card_dat_o(c_dat), .wr_cnt_o(wr_cnt));

    // pulse counters, so no one-cycle pulse is missed by a task
    always @(posedge clk_i) begin
        if (force_o === 1'b1) n_idle++;
        if (start_o === 1'b1) n_start++;
        if (pdown_o === 1'b1) n_pdown++;
        if (c_req === 1'b1) n_creq++;
    end

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(string what, logic [47:0] exp, logic [47:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one classic cycle; read data taken at the edge that sees ack
    task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
        int k;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        wsel <= 4'hF;
        adr  <= a;
        wdat <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        if (k == 20) begin
            chk("wb ack", 1, 0);
            end_of_test();
        end
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        wsel <= 4'h0;
    endtask : bus

    task automatic press(logic [3:0] b);
        bus(1'b1, CHLC_OFS_CTRL, {27'h0, sel, b});
    endtask : press

    task automatic settle(int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask : settle

    task automatic wait_start(int s0);
        int k;
        for (k = 0; k < 3000 && n_start == s0; k++) settle(0);
        if (k == 3000) begin
            chk("start pulse", 1, 0);
            end_of_test();
        end
        settle(1);
    endtask : wait_start

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_power();
        int n0;
        n0 = n_idle;
        chk("lamps after reset", 8'h14, lamps);
        press(4'h4);
        settle(20);
        chk("power main", 1, p_main);
        chk("power drum", 1, p_drum);
        chk("power lamp", 1, lamps.power_on);
        chk("idle force", n0 + 1, n_idle);
        $display("test power-on done");
    endtask : t_power

    task automatic t_halt();
        press(4'h1);
        settle(2);
        chk("proc halt", 2'h3, halt_o);
        chk("halt lamp", 1, lamps.halt);
        press(4'h2);
        settle(3);
        chk("drum req busy cpu", 0, d_req);
        chk("halt lamp kept", 1, lamps.halt);
        bus(1'b0, CHLC_OFS_STATUS, 32'h0);
        chk("state idle", 4'h1, rdat[11:8]);
        $display("test halt done");
    endtask : t_halt

    task automatic t_lamps();
        for (int f = 0; f < 4; f++) begin
            @(posedge clk_i);
            nsf    <= f[1:0];
            parity <= f[1:0];
            settle(3);
            chk("a normal", f[0], lamps.a_normal);
            chk("a control", !f[0], lamps.a_control);
            chk("b normal", f[1], lamps.b_normal);
            chk("b control", !f[1], lamps.b_control);
            chk("mem check", f != 0, lamps.mem_check);
        end
        @(posedge clk_i);
        nsf <= 2'h3;
        for (int i = 0; i < 17; i++) begin
            @(posedge clk_i);
            avail <= chlc_units_s'(~(17'h00001 << i));
            busy  <= chlc_units_s'(17'h00000);
            settle(3);
            chk("not ready", 1, lamps.not_ready);
            @(posedge clk_i);
            busy <= chlc_units_s'(17'h00001 << i);
            settle(3);
            chk("not ready busy", 0, lamps.not_ready);
        end
        @(posedge clk_i);
        avail <= chlc_units_s'(17'h1FFFF);
        settle(3);
        chk("all ready", 0, lamps.not_ready);
        $display("test lamps done");
    endtask : t_lamps

    task automatic t_drum();
        int s0;
        int c0;
        s0 = n_start;
        c0 = n_creq;
        @(posedge clk_i);
        idle  <= 2'h1;
        stall <= 1'b1;
        sel = 1'b1;
        press(4'h2);
        settle(0);
        chk("drum req", 1, d_req);
        chk("drum unit", 0, d_unit);
        chk("drum band", 0, d_band);
        settle(2);
        chk("halt lamp off", 0, lamps.halt);
        chk("proc halt off", 0, halt_o);
        press(4'h2);
        wait_start(s0);
        chk("drum words", 512, wr_cnt);
        chk("cell 20 octal", 48'hD000_0000_0000,
            chlc_far_model_inst.core_q[16]);
        chk("last drum word", 48'hD000_0000_01FF,
            chlc_far_model_inst.core_q[527]);
        chk("start adr", 15'h0010, start_adr);
        chk("one start", s0 + 1, n_start);
        chk("no card req", c0, n_creq);
        bus(1'b0, CHLC_OFS_STATUS, 32'h0);
        chk("latched drum", 0, rdat[12]);
        $display("test drum load done");
    endtask : t_drum

    task automatic t_card();
        int s0;
        int w0;
        s0 = n_start;
        w0 = wr_cnt;
        @(posedge clk_i);
        stall <= 1'b0;
        press(4'h2);
        settle(0);
        chk("card req", 1, c_req);
        chk("card unit", 0, c_unit);
        chk("drum idle", 0, d_req);
        wait_start(s0);
        chk("card words", w0 + 20, wr_cnt);
        chk("cell 20 card", 48'hC000_0000_0000,
            chlc_far_model_inst.core_q[16]);
        chk("cell 43 card", 48'hC000_0000_0013,
            chlc_far_model_inst.core_q[35]);
        chk("cell 44 kept", 48'hD000_0000_0014,
            chlc_far_model_inst.core_q[36]);
        chk("card start adr", 15'h0010, start_adr);
        bus(1'b0, CHLC_OFS_STATUS, 32'h0);
        chk("latched card", 1, rdat[12]);
        bus(1'b0, 4'h8, 32'h0);
        chk("unmapped read", 0, rdat);
        $display("test card load done");
    endtask : t_card

    task automatic t_off();
        int n0;
        n0 = n_pdown;
        press(4'h8);
        settle(3);
        chk("power down", n0 + 1, n_pdown);
        chk("power main off", 0, p_main);
        chk("power lamp off", 0, lamps.power_on);
        $display("test power-off done");
    endtask : t_off

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        settle(2);
        t_power();
        t_halt();
        t_lamps();
        t_drum();
        t_card();
        t_off();
        end_of_test();
    end
endmodule : tb_top

// [logic/chlc_console.sv]
// console halt, load and indicator control with a wishbone register port
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
module chlc_console
    import chlc_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // wishbone slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [3:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    // processors
    input  wire logic [1:0]         proc_idle_i,
    input  wire logic [1:0]         proc_parity_i,
    input  wire logic [1:0]         normal_state_flag_i,
    output logic      [1:0]         proc_halt_o,
    output logic                    proc_idle_force_o,
    output logic                    proc_start_o,
    output logic      [CHLC_AW-1:0] proc_start_adr_o,
    // unit availability
    input  wire chlc_units_s        unit_avail_i,
    input  wire chlc_units_s        unit_busy_i,
    // core memory write port
    output logic                    mem_we_o,
    output logic      [CHLC_AW-1:0] mem_adr_o,
    output logic      [CHLC_DW-1:0] mem_dat_o,
    // drum source
    output logic                    drum_req_o,
    output logic      [1:0]         drum_unit_o,
    output logic      [7:0]         drum_band_o,
    input  wire logic               drum_vld_i,
    input  wire logic [CHLC_DW-1:0] drum_dat_i,
    // card source
    output logic                    card_req_o,
    output logic      [1:0]         card_unit_o,
    input  wire logic               card_vld_i,
    input  wire logic [CHLC_DW-1:0] card_dat_i,
    // power
    output logic                    power_main_o,
    output logic                    power_drum_o,
    output logic                    power_down_o,
    // lamps
    output chlc_lamps_s             lamps_o
);

    // -----------------------------------------------------------------
    // wishbone decode
    // -----------------------------------------------------------------
    logic        ack_q;
    logic        ack_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic        req;
    logic        wr_ctrl;
    logic        halt_press;
    logic        load_press;
    logic        pon_press;
    logic        poff_press;

    // one wait state keeps read data registered
    assign req     = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_ctrl = req && wb_we_i && wb_sel_i[0]
                     && (wb_adr_i == CHLC_OFS_CTRL);

    assign halt_press = wr_ctrl && wb_dat_i[CHLC_CTL_HALT];
    assign load_press = wr_ctrl && wb_dat_i[CHLC_CTL_LOAD];
    assign pon_press  = wr_ctrl && wb_dat_i[CHLC_CTL_PON];
    assign poff_press = wr_ctrl && wb_dat_i[CHLC_CTL_POFF];

    // -----------------------------------------------------------------
    // control state
    // -----------------------------------------------------------------
    chlc_state_e        st_q;
    chlc_state_e        st_d;
    logic               sel_q;
    logic               sel_d;
    logic               lsel_q;
    logic               lsel_d;
    logic               halt_q;
    logic               halt_d;
    logic               pwr_q;
    logic               pwr_d;
    logic               pdown_q;
    logic               pdown_d;
    logic               pidle_q;
    logic               pidle_d;
    logic [9:0]         cnt_q;
    logic [9:0]         cnt_d;
    logic               we_q;
    logic               we_d;
    logic [CHLC_AW-1:0] adr_q;
    logic [CHLC_AW-1:0] adr_d;
    logic [CHLC_DW-1:0] dat_q;
    logic [CHLC_DW-1:0] dat_d;
    logic               start_q;
    logic               start_d;
    logic               accept;

    // load only from an idle processor one and an idle sequencer
    // idle gate
    assign accept = load_press && proc_idle_i[0] && (st_q == CHLC_IDLE);

    // next-state logic for halt, power, and the load sequencer
    always_comb begin
        st_d    = st_q;
        sel_d   = sel_q;
        lsel_d  = lsel_q;
        halt_d  = halt_q;
        pwr_d   = pwr_q;
        pdown_d = 1'b0;
        pidle_d = 1'b0;
        cnt_d   = cnt_q;
        we_d    = 1'b0;
        adr_d   = adr_q;
        dat_d   = dat_q;
        start_d = 1'b0;
        if (wr_ctrl) begin
            sel_d = wb_dat_i[CHLC_CTL_SEL];
        end
        if (halt_press) begin
            halt_d = 1'b1;
        end
        if (pon_press) begin
            pwr_d   = 1'b1;
            pidle_d = 1'b1;
        end
        if (poff_press) begin
            pwr_d   = 1'b0;
            pdown_d = 1'b1;
        end
        unique case (st_q)
            CHLC_IDLE: begin
                if (accept) begin
                    halt_d = 1'b0;
                    lsel_d = sel_q;
                    cnt_d  = 10'h000;
                    adr_d  = CHLC_LOAD_BASE;
                    st_d   = sel_q ? CHLC_CARD : CHLC_DRUM;
                end
            end
            CHLC_DRUM: begin
                if (drum_vld_i) begin
                    we_d  = 1'b1;
                    dat_d = drum_dat_i;
                    adr_d = CHLC_LOAD_BASE + CHLC_AW'(cnt_q);
                    cnt_d = cnt_q + 10'h001;
                    if (cnt_q == CHLC_DRUM_WRDS - 10'h001) begin
                        st_d = CHLC_START;
                    end
                end
            end
            CHLC_CARD: begin
                if (card_vld_i) begin
                    we_d  = 1'b1;
                    dat_d = card_dat_i;
                    adr_d = CHLC_LOAD_BASE + CHLC_AW'(cnt_q);
                    cnt_d = cnt_q + 10'h001;
                    if (cnt_q == CHLC_CARD_WRDS - 10'h001) begin
                        st_d = CHLC_START;
                    end
                end
            end
            CHLC_START: begin
                start_d = 1'b1;
                st_d    = CHLC_IDLE;
            end
            default: begin
                st_d = CHLC_IDLE;
            end
        endcase
    end

    // registers for the control state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q    <= CHLC_IDLE;
            sel_q   <= CHLC_SEL_RST;
            lsel_q  <= CHLC_SEL_RST;
            halt_q  <= 1'b0;
            pwr_q   <= 1'b0;
            pdown_q <= 1'b0;
            pidle_q <= 1'b0;
            cnt_q   <= 10'h000;
            we_q    <= 1'b0;
            adr_q   <= '0;
            dat_q   <= '0;
            start_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            sel_q   <= sel_d;
            lsel_q  <= lsel_d;
            halt_q  <= halt_d;
            pwr_q   <= pwr_d;
            pdown_q <= pdown_d;
            pidle_q <= pidle_d;
            cnt_q   <= cnt_d;
            we_q    <= we_d;
            adr_q   <= adr_d;
            dat_q   <= dat_d;
            start_q <= start_d;
        end
    end

    // -----------------------------------------------------------------
    // lamps
    // -----------------------------------------------------------------
    chlc_lamps_s lamp_q;
    chlc_lamps_s lamp_d;

    // lamps are registered so the panel never sees glitches
    always_comb begin
        lamp_d           = '0;
        lamp_d.halt      = halt_q;
        lamp_d.not_ready = |(~unit_avail_i & ~unit_busy_i);
        lamp_d.mem_check = |proc_parity_i;
        lamp_d.a_normal  = normal_state_flag_i[0];
        lamp_d.a_control = !normal_state_flag_i[0];
        lamp_d.b_normal  = normal_state_flag_i[1];
        lamp_d.b_control = !normal_state_flag_i[1];
        lamp_d.power_on  = pwr_q;
    end

    // lamp register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lamp_q <= '0;
        end else begin
            lamp_q <= lamp_d;
        end
    end

    // -----------------------------------------------------------------
    // wishbone answer
    // -----------------------------------------------------------------
    // unmapped addresses ack with zero data and writes are dropped
    always_comb begin
        ack_d  = req;
        rdat_d = 32'h0000_0000;
        if (req && !wb_we_i) begin
            if (wb_adr_i == CHLC_OFS_CTRL) begin
                rdat_d[CHLC_CTL_SEL] = sel_q;
            end else if (wb_adr_i == CHLC_OFS_STATUS) begin
                rdat_d[7:0]  = lamp_q;
                rdat_d[11:8] = st_q;
                rdat_d[12]   = lsel_q;
            end
        end
    end

    // bus answer register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign wb_ack_o  = ack_q;
    assign wb_dat_o  = rdat_q;
    assign lamps_o   = lamp_q;
    // processors finish the current syllable before honouring this
    assign proc_halt_o       = {2{halt_q}};
    assign proc_idle_force_o = pidle_q;
    assign proc_start_o      = start_q;
    assign proc_start_adr_o  = CHLC_LOAD_BASE;
    assign mem_we_o  = we_q;
    assign mem_adr_o = adr_q;
    assign mem_dat_o = dat_q;
    assign drum_req_o  = (st_q == CHLC_DRUM);
    assign drum_unit_o = CHLC_DRUM_UNIT;
    assign drum_band_o = CHLC_DRUM_BAND;
    assign card_req_o  = (st_q == CHLC_CARD);
    assign card_unit_o = CHLC_CARD_UNIT;
    assign power_main_o = pwr_q;
    assign power_drum_o = pwr_q;
    assign power_down_o = pdown_q;

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    property p_halt_set;
        @(posedge clk_i) disable iff (rst_i)
        halt_press && !accept |=> halt_q ##1 lamps_o.halt;
    endproperty
    a_halt_set: assert property (p_halt_set)
        else $error("halt press did not light halt");

    property p_halt_hold;
        @(posedge clk_i) disable iff (rst_i)
        halt_q && !accept |=> halt_q;
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("halt dropped without a load");

    property p_notready;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> lamps_o.not_ready ==
            $past(|(~unit_avail_i & ~unit_busy_i));
    endproperty
    a_notready: assert property (p_notready)
        else $error("not-ready lamp wrong");

    property p_memchk;
        @(posedge clk_i) disable iff (rst_i)
        $rose(|proc_parity_i) |=> lamps_o.mem_check;
    endproperty
    a_memchk: assert property (p_memchk)
        else $error("memory check lamp missed");

    property p_load_gate;
        @(posedge clk_i) disable iff (rst_i)
        st_q == CHLC_IDLE && !accept |=> st_q == CHLC_IDLE;
    endproperty
    a_load_gate: assert property (p_load_gate)
        else $error("load started without acceptance");

    property p_drum_end;
        @(posedge clk_i) disable iff (rst_i)
        st_q == CHLC_DRUM && drum_vld_i && cnt_q == 10'h1FF
        |=> st_q == CHLC_START ##1 proc_start_o;
    endproperty
    a_drum_end: assert property (p_drum_end)
        else $error("drum load length wrong");

    property p_start_adr;
        @(posedge clk_i) disable iff (rst_i)
        proc_start_o |-> proc_start_adr_o == 15'h0010;
    endproperty
    a_start_adr: assert property (p_start_adr)
        else $error("start address not cell 20 octal");

    property p_card_span;
        @(posedge clk_i) disable iff (rst_i)
        mem_we_o && lsel_q |-> mem_adr_o inside {[15'h0010:15'h0023]};
    endproperty
    a_card_span: assert property (p_card_span)
        else $error("card word outside cells 20 to 43");

    property p_lamp_a;
        @(posedge clk_i) disable iff (rst_i)
        !rst_i |=> lamps_o.a_normal != lamps_o.a_control
        && lamps_o.a_normal == $past(normal_state_flag_i[0]);
    endproperty
    a_lamp_a: assert property (p_lamp_a)
        else $error("processor one lamps wrong");

    property p_lamp_b;
        @(posedge clk_i) disable iff (rst_i)
        !rst_i |=> lamps_o.b_normal == $past(normal_state_flag_i[1])
        && lamps_o.b_control == !$past(normal_state_flag_i[1]);
    endproperty
    a_lamp_b: assert property (p_lamp_b)
        else $error("processor two lamps wrong");

    property p_pwr;
        @(posedge clk_i) disable iff (rst_i)
        pon_press && !poff_press |=> power_main_o && power_drum_o
            && proc_idle_force_o ##1 lamps_o.power_on;
    endproperty
    a_pwr: assert property (p_pwr)
        else $error("power on sequence wrong");

    property p_poff;
        @(posedge clk_i) disable iff (rst_i)
        poff_press |=> power_down_o && !power_main_o;
    endproperty
    a_poff: assert property (p_poff)
        else $error("power off not started");

    property p_sel_hold;
        @(posedge clk_i) disable iff (rst_i)
        st_q != CHLC_IDLE |=> $stable(lsel_q);
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("load source changed mid load");

endmodule : chlc_console

// [logic/chlc_pkg.sv]
// constants and types for the console halt and load control
//
// Function
// - halt press stops both processors at syllable end, lights halt lamp
// - halt lamp stays lit until a load press actually starts a load
// - not-ready lamp lights when a checked unit becomes unavailable
// - checked: processors, memory, I/O controls, drums, message printer
// - a unit unavailable only because busy does not light not-ready
// - memory-check lamp lights while either parity interrupt is set
// - load press is ignored unless processor one is idle
// - drum load copies 512 words from drum one band 0 to cell 20 octal
// - after a drum load processor one starts at cell 20 octal
// - card load reads one card into cells 20 to 43 octal, then starts
// - card load always uses card reader one
// - processor one normal lamp on flag 1, control lamp on flag 0
// - processor two normal lamp on flag 1, control lamp on flag 0
// - power-on powers frame and drum, idles processors, lamp stays lit
// - power-off starts power-down of the whole system and its I/O
package chlc_pkg;

    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam logic [3:0] CHLC_OFS_CTRL   = 4'h0;
    localparam logic [3:0] CHLC_OFS_STATUS = 4'h4;

    // control register bit positions
    localparam int CHLC_CTL_HALT  = 0;
    localparam int CHLC_CTL_LOAD  = 1;
    localparam int CHLC_CTL_PON   = 2;
    localparam int CHLC_CTL_POFF  = 3;
    localparam int CHLC_CTL_SEL   = 4;
    localparam logic CHLC_SEL_RST = 1'b0;

    // -----------------------------------------------------------------
    // load geometry
    // -----------------------------------------------------------------
    localparam int          CHLC_AW        = 15;
    localparam int          CHLC_DW        = 48;
    localparam logic [14:0] CHLC_LOAD_BASE = 15'h0010;
    localparam logic [9:0]  CHLC_DRUM_WRDS = 10'h200;
    localparam logic [9:0]  CHLC_CARD_WRDS = 10'h014;
    localparam logic [1:0]  CHLC_DRUM_UNIT = 2'h0;
    localparam logic [1:0]  CHLC_CARD_UNIT = 2'h0;
    localparam logic [7:0]  CHLC_DRUM_BAND = 8'h00;

    // checked unit population
    localparam int CHLC_NMEM = 8;
    localparam int CHLC_NIOC = 4;

    typedef struct packed {
        logic [1:0]           proc;
        logic [CHLC_NMEM-1:0] mem;
        logic [CHLC_NIOC-1:0] ioc;
        logic [1:0]           drum;
        logic                 spo;
    } chlc_units_s;

    typedef struct packed {
        logic halt;
        logic not_ready;
        logic mem_check;
        logic a_normal;
        logic a_control;
        logic b_normal;
        logic b_control;
        logic power_on;
    } chlc_lamps_s;

    typedef enum logic [3:0] {
        CHLC_IDLE  = 4'h1,
        CHLC_DRUM  = 4'h2,
        CHLC_CARD  = 4'h4,
        CHLC_START = 4'h8
    } chlc_state_e;

endpackage : chlc_pkg
